// ==== count_source.sv ====
// external count clock source driving the count input pin
`timescale 1ns/1ps
`default_nettype none
module count_source
(
  input wire logic aclk,
  input wire logic go,
  input wire logic [7:0] toggles,
  input wire logic [7:0] half,
  output logic pin,
  output logic busy
);
  logic [7:0] left_ff;
  logic [7:0] tick_ff;
  initial
  begin
    pin = 1'b0;
    busy = 1'b0;
    left_ff = 8'h00;
    tick_ff = 8'h00;
  end
  // toggles the pin a set number of times, holding each level half+1 cycles
  always @(posedge aclk)
  begin
    if (go)
    begin
      left_ff <= toggles;
      tick_ff <= half;
      busy <= 1'b1;
    end
    else if (left_ff != 8'h00)
    begin
      if (tick_ff == 8'h00)
      begin
        pin <= ~pin; // each level held well over two clock phases
        left_ff <= left_ff - 8'h01;
        tick_ff <= half;
      end
      else
        tick_ff <= tick_ff - 8'h01;
    end
    else
      busy <= 1'b0;
  end
endmodule
`default_nettype wire

// ==== testbench.sv ====
// self-checking bench for the 8-bit timer with shared prescaler
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import timer8_pkg::*;
  logic aclk = 1'b0;
  logic aresetn = 1'b0;
  logic sleep_mode = 1'b0;
  logic watchdog_tick = 1'b0;
  logic watchdog_clear = 1'b0;
  logic [ADDR_W-1:0] awaddr = '0;
  logic [ADDR_W-1:0] araddr = '0;
  logic awvalid = 1'b0, wvalid = 1'b0, arvalid = 1'b0, go = 1'b0;
  logic bready = 1'b1, rready = 1'b1;
  logic [31:0] wdata = 32'h0;
  logic [7:0] toggles = 8'h00;
  logic awready, wready, bvalid, arready, rvalid, overflow_irq, watchdog_timeout;
  logic count_input_pin, busy;
  logic [1:0] bresp, rresp;
  logic [31:0] rdata, rd;
  int n_mismatch = 0, n_checks = 0;
  always #10 aclk = ~aclk;
  timer8_with_shared_prescaler dut (.aclk, .aresetn, .count_input_pin, .sleep_mode,
    .watchdog_tick, .watchdog_clear, .awaddr, .awvalid, .awready, .wdata, .wstrb(4'hf),
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .overflow_irq, .watchdog_timeout);
  count_source src (.aclk, .go, .toggles, .half(8'h06), .pin(count_input_pin), .busy);
  // ------------------------------------------------------------
  // checks and bus tasks
  // ------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chkr(input logic [31:0] got, input logic [31:0] lo, input logic [31:0] hi);
    n_checks++;
    if ((got >= lo && got <= hi) !== 1'b1)
    begin
      n_mismatch++;
      $display("MISMATCH %0t got %h outside %h..%h", $time, got, lo, hi);
    end
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d, input logic [1:0] er);
    logic a;
    logic w;
    a = 1'b1;
    w = 1'b1;
    awaddr <= {2'b00, idx, 2'b00};
    wdata <= {24'h0, d};
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (a || w)
    begin
      @(posedge aclk);
      if (a && awready)
      begin
        awvalid <= 1'b0;
        a = 1'b0;
      end
      if (w && wready)
      begin
        wvalid <= 1'b0;
        w = 1'b0;
      end
    end
    do @(posedge aclk); while (bvalid !== 1'b1);
    chk({30'h0, bresp}, {30'h0, er});
  endtask
  task automatic rdr(input logic [7:0] idx, input logic [1:0] er);
    araddr <= {2'b00, idx, 2'b00};
    arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rd = rdata;
    chk({30'h0, rresp}, {30'h0, er});
  endtask
  task automatic rc(input logic [7:0] idx, input logic [31:0] exp);
    rdr(idx, RESP_OKAY);
    chk(rd, exp);
  endtask
  task automatic burst(input logic [7:0] n);
    toggles <= n;
    go <= 1'b1;
    @(posedge aclk);
    go <= 1'b0;
    do @(posedge aclk); while (busy !== 1'b0);
    repeat (12) @(posedge aclk);
  endtask
  task automatic tk(input logic clr, input logic exp);
    watchdog_tick <= !clr;
    watchdog_clear <= clr;
    @(posedge aclk);
    watchdog_tick <= 1'b0;
    watchdog_clear <= 1'b0;
    @(posedge aclk);
    chk({31'h0, watchdog_timeout}, {31'h0, exp});
  endtask
  task automatic wrap_up();
    if (n_mismatch == 0 && n_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // ------------------------------------------------------------
  // test sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rc(IDX_COUNT, {24'h0, COUNT_RESET});
    rc(IDX_IRQ_CTRL, {24'h0, IRQ_CTRL_RESET});
    rc(IDX_OPTION, {24'h0, OPTION_RESET});
    rc(IDX_PORT_DIR, {26'h0, PORT_DIR_RESET});
    rdr(8'h40, RESP_SLVERR);
    chk(rd, 32'h0);
    wr(8'h40, 8'h55, RESP_SLVERR);
    wr(IDX_OPTION, 8'h08, RESP_OKAY);
    wr(IDX_COUNT, 8'h10, RESP_OKAY);
    rc(IDX_COUNT, 32'h10);
    repeat (40) @(posedge aclk);
    rdr(IDX_COUNT, RESP_OKAY);
    chkr(rd, 32'h18, 32'h19);
    wr(IDX_IRQ_CTRL, 8'h20, RESP_OKAY);
    wr(IDX_COUNT, 8'hfe, RESP_OKAY);
    repeat (30) @(posedge aclk);
    chk({31'h0, overflow_irq}, 32'h1);
    rc(IDX_IRQ_CTRL, 32'h24);
    wr(IDX_IRQ_CTRL, 8'h04, RESP_OKAY);
    repeat (100) @(posedge aclk);
    chk({31'h0, overflow_irq}, 32'h0);
    rc(IDX_IRQ_CTRL, 32'h04);
    wr(IDX_IRQ_CTRL, 8'h00, RESP_OKAY);
    rc(IDX_IRQ_CTRL, 32'h00);
    sleep_mode <= 1'b1;
    wr(IDX_COUNT, 8'h40, RESP_OKAY);
    repeat (40) @(posedge aclk);
    rc(IDX_COUNT, 32'h40);
    sleep_mode <= 1'b0;
    for (int n = 0; n < 3; n++)
    begin
      wr(IDX_OPTION, 8'(n), RESP_OKAY);
      wr(IDX_COUNT, 8'h00, RESP_OKAY);
      repeat (400) @(posedge aclk);
      rdr(IDX_COUNT, RESP_OKAY);
      chkr(rd, (32'd400 >> (n + 3)) - 32'd3, (32'd400 >> (n + 3)) + 32'd1);
    end
    wr(IDX_OPTION, 8'h28, RESP_OKAY);
    wr(IDX_COUNT, 8'h00, RESP_OKAY);
    repeat (10) @(posedge aclk);
    burst(8'd5);
    rc(IDX_COUNT, 32'h03);
    wr(IDX_OPTION, 8'h38, RESP_OKAY);
    wr(IDX_COUNT, 8'h00, RESP_OKAY);
    repeat (10) @(posedge aclk);
    burst(8'd5);
    rc(IDX_COUNT, 32'h03);
    wr(IDX_OPTION, 8'h20, RESP_OKAY);
    wr(IDX_COUNT, 8'h00, RESP_OKAY);
    repeat (10) @(posedge aclk);
    burst(8'd8);
    rc(IDX_COUNT, 32'h02);
    wr(IDX_OPTION, 8'h21, RESP_OKAY);
    wr(IDX_COUNT, 8'h00, RESP_OKAY);
    wr(IDX_OPTION, 8'h09, RESP_OKAY);
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    tk(1'b0, 1'b1);
    tk(1'b0, 1'b0);
    tk(1'b1, 1'b0);
    tk(1'b0, 1'b0);
    wr(IDX_OPTION, 8'h08, RESP_OKAY);
    tk(1'b0, 1'b1);
    tk(1'b1, 1'b0);
    wr(IDX_OPTION, 8'h00, RESP_OKAY);
    tk(1'b0, 1'b1);
    wrap_up();
  end
  initial
  begin
    repeat (20000) @(posedge aclk);
    n_mismatch++;
    wrap_up();
  end
endmodule
`default_nettype wire

// ==== timer8_pkg.sv ====
// constants shared by the 8-bit timer with shared prescaler
// Summary of operation
// R01 - clock source select clear: count once per instruction cycle without prescaler
// R02 - after a write to the count, counting stops for two instruction cycles
// R03 - clock source select set: count edges of the external count input
// R04 - edge select zero counts rising edges, one counts falling edges
// R05 - one prescaler serves timer or watchdog; assignment bit clear gives timer
// R06 - prescaler count is never readable or writable, only cleared by side effects
// R07 - timer prescaler ratio is a power of two from 1:2 to 1:256
// R08 - ratio codes 0..7 give 1:2..1:256 for timer, 1:1..1:128 for watchdog
// R09 - count wrap from ff to 00 sets the overflow flag
// R10 - interrupt request only while overflow interrupt enable is set; flag unaffected
// R11 - overflow flag stays set until software clears it
// R12 - timer is stopped during sleep, so overflow cannot wake the core
// R13 - prescaler output is sampled on second and fourth clock phases
// R14 - synchronising stage sits after the prescaler
// R15 - prescaler is a ripple-style divider giving a symmetrical square wave
// R16 - count updates some clock phases after the external edge
// R17 - shared divider is 8 bits: prescaler for timer, postscaler for watchdog
// R18 - with prescaler on timer, any count write clears the prescaler
// R19 - with prescaler on watchdog, watchdog clear also clears the prescaler
// R20 - prescaler assignment may change at any time while running
// R21 - software clears count, selects watchdog, clears watchdog, then sets ratio
// R22 - for a final watchdog ratio 1:1, software uses a temporary ratio first
// R23 - software clears the watchdog before moving the prescaler to the timer
package timer8_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_COUNT = 8'h01;
  localparam logic [7:0] IDX_IRQ_CTRL = 8'h0b;
  localparam logic [7:0] IDX_OPTION = 8'h81;
  localparam logic [7:0] IDX_PORT_DIR = 8'h85;
  localparam int ADDR_W = 12;
  // field positions
  localparam int OVF_FLAG_BIT = 2;
  localparam int OVF_EN_BIT = 5;
  localparam int OPT_CS_BIT = 5;
  localparam int OPT_SE_BIT = 4;
  localparam int OPT_PSA_BIT = 3;
  // reset values
  localparam logic [7:0] COUNT_RESET = 8'h00;
  localparam logic [7:0] IRQ_CTRL_RESET = 8'h00;
  localparam logic [7:0] OPTION_RESET = 8'hff;
  localparam logic [5:0] PORT_DIR_RESET = 6'h3f;
  // clock phases within one instruction cycle
  localparam logic [1:0] PHASE_SECOND = 2'h1;
  localparam logic [1:0] PHASE_FOURTH = 2'h3;
  localparam int PHASES_PER_INSTR = 4;
  localparam int INHIBIT_INSTR = 2;
  localparam logic [3:0] INHIBIT_CYCLES = 4'(INHIBIT_INSTR * PHASES_PER_INSTR);
  // bus responses
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// ==== timer8_with_shared_prescaler.sv ====
// 8-bit timer/counter with shared prescaler, AXI4-Lite register slave
//
// Our own choice: the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module timer8_with_shared_prescaler
  import timer8_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic count_input_pin,
  input wire logic sleep_mode,
  input wire logic watchdog_tick,
  input wire logic watchdog_clear,
  input wire logic [ADDR_W-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [ADDR_W-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic overflow_irq,
  output logic watchdog_timeout
);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [1:0] phase_ff;
    logic pin_s1_ff;
    logic pin_s2_ff;
    logic pin_prev_ff;
    logic [7:0] pre_cnt_ff;
    logic samp_ff;
    logic [7:0] count_ff;
    logic [7:0] irq_ctrl_ff;
    logic [7:0] option_ff;
    logic [5:0] port_dir_ff;
    logic [3:0] inhibit_ff;
    logic irq_ff;
    logic wdt_out_ff;
    logic awready_ff;
    logic aw_got_ff;
    logic [ADDR_W-1:0] aw_addr_ff;
    logic wready_ff;
    logic w_got_ff;
    logic [7:0] wdata_ff;
    logic wstrb0_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;
  } state_t;

  localparam state_t RESET_ST = '{
    count_ff: COUNT_RESET,
    irq_ctrl_ff: IRQ_CTRL_RESET,
    option_ff: OPTION_RESET,
    port_dir_ff: PORT_DIR_RESET,
    samp_ff: 1'b1,
    awready_ff: 1'b1,
    wready_ff: 1'b1,
    arready_ff: 1'b1,
    default: '0
  };

  state_t st_ff;
  state_t nxt_st;

  logic instr_tick;
  logic sample_now;
  logic clk_sel;
  logic edge_sel;
  logic pre_to_wdt;
  logic [2:0] ratio;
  logic pin_edge;
  logic pre_src;
  logic pre_clr;
  logic [7:0] pre_inc;
  logic [2:0] wdt_bit;
  logic wdt_fire;
  logic tmr_level;
  logic tmr_rise;
  logic inc_src;
  logic inc_fire;
  logic ovf;
  logic do_write;
  logic [7:0] w_idx;
  logic [7:0] r_idx;
  logic w_mapped;
  logic wr_count;
  logic wr_irq_ctrl;
  logic wr_option;
  logic wr_port_dir;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb
  begin
    nxt_st = st_ff;
    // four clock phases per instruction cycle
    nxt_st.phase_ff = st_ff.phase_ff + 2'h1;
    instr_tick = (st_ff.phase_ff == PHASE_FOURTH);
    sample_now = (st_ff.phase_ff == PHASE_SECOND) || (st_ff.phase_ff == PHASE_FOURTH);
    clk_sel = st_ff.option_ff[OPT_CS_BIT];
    edge_sel = st_ff.option_ff[OPT_SE_BIT];
    pre_to_wdt = st_ff.option_ff[OPT_PSA_BIT];
    ratio = st_ff.option_ff[2:0];

    // bus write: address and data taken in either order
    if (awvalid && st_ff.awready_ff)
    begin
      nxt_st.aw_got_ff = 1'b1;
      nxt_st.aw_addr_ff = awaddr;
    end
    if (wvalid && st_ff.wready_ff)
    begin
      nxt_st.w_got_ff = 1'b1;
      nxt_st.wdata_ff = wdata[7:0];
      nxt_st.wstrb0_ff = wstrb[0];
    end
    if (st_ff.bvalid_ff && bready)
    begin
      nxt_st.bvalid_ff = 1'b0;
    end
    do_write = st_ff.aw_got_ff && st_ff.w_got_ff && !st_ff.bvalid_ff;
    w_idx = st_ff.aw_addr_ff[9:2];
    w_mapped = (st_ff.aw_addr_ff[ADDR_W-1:10] == '0) &&
      ((w_idx == IDX_COUNT) || (w_idx == IDX_IRQ_CTRL) ||
       (w_idx == IDX_OPTION) || (w_idx == IDX_PORT_DIR));
    wr_count = do_write && st_ff.wstrb0_ff && (w_idx == IDX_COUNT);
    wr_irq_ctrl = do_write && st_ff.wstrb0_ff && (w_idx == IDX_IRQ_CTRL);
    wr_option = do_write && st_ff.wstrb0_ff && (w_idx == IDX_OPTION);
    wr_port_dir = do_write && st_ff.wstrb0_ff && (w_idx == IDX_PORT_DIR);
    if (do_write)
    begin
      nxt_st.aw_got_ff = 1'b0;
      nxt_st.w_got_ff = 1'b0;
      nxt_st.bvalid_ff = 1'b1;
      nxt_st.bresp_ff = w_mapped ? RESP_OKAY : RESP_SLVERR;
    end
    nxt_st.awready_ff = !nxt_st.aw_got_ff && !nxt_st.bvalid_ff;
    nxt_st.wready_ff = !nxt_st.w_got_ff && !nxt_st.bvalid_ff;
    // assignment may change at any moment [R20]
    if (wr_option)
    begin
      nxt_st.option_ff = st_ff.wdata_ff;
    end
    if (wr_port_dir)
    begin
      nxt_st.port_dir_ff = st_ff.wdata_ff[5:0];
    end

    // external input: two-stage synchroniser, then edge choice
    nxt_st.pin_s1_ff = count_input_pin;
    nxt_st.pin_s2_ff = st_ff.pin_s1_ff;
    nxt_st.pin_prev_ff = st_ff.pin_s2_ff;
    // rising edge when edge select clear, falling when set [R04]
    pin_edge = edge_sel ? (st_ff.pin_prev_ff && !st_ff.pin_s2_ff)
                        : (!st_ff.pin_prev_ff && st_ff.pin_s2_ff);

    // shared 8-bit divider, prescaler or watchdog postscaler [R05] [R17]
    pre_src = pre_to_wdt ? watchdog_tick : (clk_sel ? pin_edge : instr_tick);
    pre_inc = st_ff.pre_cnt_ff + 8'h01;
    // cleared only by count write or watchdog clear, never loaded [R06] [R18] [R19]
    pre_clr = (wr_count && !pre_to_wdt) || (watchdog_clear && pre_to_wdt);
    if (pre_clr)
    begin
      nxt_st.pre_cnt_ff = 8'h00;
    end
    else if (pre_src)
    begin
      // each bit toggles at half the rate of the one below [R15]
      nxt_st.pre_cnt_ff = pre_inc;
    end

    // watchdog side: code 0 is 1:1, each step doubles [R08]
    wdt_bit = ratio - 3'h1;
    wdt_fire = pre_src && !pre_clr &&
      ((ratio == 3'h0) || (st_ff.pre_cnt_ff[wdt_bit] && !pre_inc[wdt_bit]));
    nxt_st.wdt_out_ff = pre_to_wdt ? wdt_fire : watchdog_tick;

    // timer side: divider bit selects 1:2..1:256 [R07] [R08]
    tmr_level = pre_to_wdt ? (st_ff.pin_s2_ff ^ edge_sel) : st_ff.pre_cnt_ff[ratio];
    // sampling after the divider, on second and fourth phases [R13] [R14]
    if (sample_now)
    begin
      nxt_st.samp_ff = tmr_level;
    end
    // count moves on the sampled edge, phases after the pin edge [R16]
    tmr_rise = sample_now && tmr_level && !st_ff.samp_ff;
    // timer mode without prescaler counts each instruction [R01] [R03]
    inc_src = (pre_to_wdt && !clk_sel) ? instr_tick : tmr_rise;
    // no counting in sleep or just after a count write [R12] [R02]
    inc_fire = inc_src && !sleep_mode && (st_ff.inhibit_ff == 4'h0) && !wr_count;

    if (wr_count)
    begin
      nxt_st.count_ff = st_ff.wdata_ff;
      nxt_st.inhibit_ff = INHIBIT_CYCLES; // [R02]
    end
    else
    begin
      if (st_ff.inhibit_ff != 4'h0)
      begin
        nxt_st.inhibit_ff = st_ff.inhibit_ff - 4'h1;
      end
      if (inc_fire)
      begin
        nxt_st.count_ff = st_ff.count_ff + 8'h01;
      end
    end

    // overflow flag: hardware set wins over software clear [R09] [R11]
    ovf = inc_fire && (st_ff.count_ff == 8'hff);
    if (wr_irq_ctrl)
    begin
      nxt_st.irq_ctrl_ff = st_ff.wdata_ff;
    end
    if (ovf)
    begin
      nxt_st.irq_ctrl_ff[OVF_FLAG_BIT] = 1'b1;
    end
    // request gated by enable, flag untouched by it [R10]
    nxt_st.irq_ff = nxt_st.irq_ctrl_ff[OVF_FLAG_BIT] && nxt_st.irq_ctrl_ff[OVF_EN_BIT];

    // bus read
    r_idx = araddr[9:2];
    if (st_ff.rvalid_ff && rready)
    begin
      nxt_st.rvalid_ff = 1'b0;
      nxt_st.arready_ff = 1'b1;
    end
    if (arvalid && st_ff.arready_ff)
    begin
      nxt_st.arready_ff = 1'b0;
      nxt_st.rvalid_ff = 1'b1;
      nxt_st.rresp_ff = RESP_OKAY;
      nxt_st.rdata_ff = 32'h0000_0000;
      if (araddr[ADDR_W-1:10] != '0)
      begin
        nxt_st.rresp_ff = RESP_SLVERR;
      end
      else
      begin
        case (r_idx)
          IDX_COUNT: nxt_st.rdata_ff[7:0] = st_ff.count_ff;
          IDX_IRQ_CTRL: nxt_st.rdata_ff[7:0] = st_ff.irq_ctrl_ff;
          IDX_OPTION: nxt_st.rdata_ff[7:0] = st_ff.option_ff;
          IDX_PORT_DIR: nxt_st.rdata_ff[5:0] = st_ff.port_dir_ff;
          default: nxt_st.rresp_ff = RESP_SLVERR;
        endcase
      end
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      st_ff <= RESET_ST;
    end
    else
    begin
      st_ff <= nxt_st;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign awready = st_ff.awready_ff;
  assign wready = st_ff.wready_ff;
  assign bvalid = st_ff.bvalid_ff;
  assign bresp = st_ff.bresp_ff;
  assign arready = st_ff.arready_ff;
  assign rvalid = st_ff.rvalid_ff;
  assign rdata = st_ff.rdata_ff;
  assign rresp = st_ff.rresp_ff;
  assign overflow_irq = st_ff.irq_ff;
  assign watchdog_timeout = st_ff.wdt_out_ff;

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  a_write_inhibit: assert property (wr_count |=> (!inc_fire)[*8]) // [R02]
    else $error("count moved within two instruction cycles of a write");
  a_timer_rate: assert property (
    (!clk_sel && pre_to_wdt && !sleep_mode && st_ff.inhibit_ff == 4'h0 && !wr_count && instr_tick)
    |-> inc_fire) // [R01]
    else $error("timer mode missed an instruction cycle");
  a_counter_edge: assert property (
    (clk_sel && pre_to_wdt && !sleep_mode && st_ff.inhibit_ff == 4'h0 && !wr_count && tmr_rise)
    |=> st_ff.count_ff == $past(st_ff.count_ff) + 8'h01) // [R03]
    else $error("counter mode missed a sampled edge");
  a_flag_on_wrap: assert property (
    (inc_fire && st_ff.count_ff == 8'hff)
    |=> st_ff.count_ff == 8'h00 && st_ff.irq_ctrl_ff[OVF_FLAG_BIT]) // [R09]
    else $error("wrap did not set the overflow flag");
  a_flag_sticky: assert property (
    (st_ff.irq_ctrl_ff[OVF_FLAG_BIT] && !wr_irq_ctrl) |=> st_ff.irq_ctrl_ff[OVF_FLAG_BIT]) // [R11]
    else $error("overflow flag dropped without a software clear");
  a_irq_masked: assert property (
    overflow_irq |-> st_ff.irq_ctrl_ff[OVF_EN_BIT] && st_ff.irq_ctrl_ff[OVF_FLAG_BIT]) // [R10]
    else $error("interrupt request while masked or flag clear");
  a_sleep_stops: assert property (
    sleep_mode |=> st_ff.count_ff == $past(st_ff.count_ff) || $past(wr_count)) // [R12]
    else $error("timer counted during sleep");
  a_count_clr_pre: assert property ((wr_count && !pre_to_wdt) |=> st_ff.pre_cnt_ff == 8'h00) // [R18]
    else $error("count write did not clear the prescaler");
  a_wdt_clr_pre: assert property ((watchdog_clear && pre_to_wdt) |=> st_ff.pre_cnt_ff == 8'h00) // [R19]
    else $error("watchdog clear did not clear the prescaler");
  a_sample_phase: assert property (
    $changed(st_ff.samp_ff) |-> $past(st_ff.phase_ff) == PHASE_SECOND ||
      $past(st_ff.phase_ff) == PHASE_FOURTH) // [R13]
    else $error("prescaler output sampled off the second and fourth phases");

  c_overflow: cover property (inc_fire && st_ff.count_ff == 8'hff);
  c_wdt_post: cover property (pre_to_wdt && wdt_fire && ratio != 3'h0);
  c_count_write: cover property (wr_count ##1 st_ff.inhibit_ff == INHIBIT_CYCLES);
  c_irq: cover property ($rose(overflow_irq));

endmodule
`default_nettype wire
